/* File: core/tsc_regs.sv */
/*
 Register bank, power state control and status flags of the touch sensor.
 Assumes decoded byte accesses from a serial front end and sensing inputs already in the mclk domain.
*/
`timescale 1ns/1ns
`default_nettype none
module tsc_regs
	import tsc_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             wrEn,
	input  wire logic             rdEn,
	input  wire logic [7:0]       addr,
	input  wire logic [7:0]       wrData,
	output logic      [7:0]       rdData,
	input  wire logic [NCH-1:0]   touchRaw,
	input  wire logic [NCH-1:0]   intEnable,
	input  wire logic [NCH-1:0]   standbyChannels,
	input  wire logic [NCH-1:0]   ledDoneEvt,
	input  wire logic             multiTouchBlocking,
	input  wire logic             patternMatch,
	input  wire logic             patternAlertEnable,
	input  wire logic [7:0]       calUpper1,
	input  wire logic [7:0]       calUpper2,
	input  wire logic [7:0]       calUpper3,
	input  wire logic [7:0]       calLowBits,
	output logic      [1:0]       gainCode,
	output logic      [3:0]       gainFactor,
	output logic      [NCH-1:0]   scanEnable,
	output logic                  ledsIdle,
	output logic                  pwmHalt,
	output logic      [NCH-1:0]   ledLinkMask,
	output logic                  alertOut,
	output logic                  alertOe_n
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]           main;
		logic [NCH-1:0]       touched;
		logic [NCH-1:0]       ledDone;
		logic                 patternFlag;
		logic                 multiFlag;
		logic [RW_COUNT-1:0][7:0] rwRegs;
		logic [7:0]           ramp;
		logic [7:0]           offDelay;
		logic [7:0]           rdData;
		logic [1:0]           gainCode;
		logic [3:0]           gainFactor;
		logic [NCH-1:0]       scanEnable;
		logic                 ledsIdle;
		logic                 pwmHalt;
		logic [NCH-1:0]       ledLinkMask;
		logic                 alertOe_n;
	} tsc_state_t;

	tsc_state_t stateReg;
	tsc_state_t stateNext;
	tsc_state_t stateRst;

	logic [NCH-1:0] sampled;
	logic [NCH-1:0] touchSeen;
	logic           intClear;
	logic           enterSleep;
	logic [7:0]     genStatus;
	logic [7:0]     rdMux;
	logic [NCH-1:0] linkNext;

	always_comb begin
		stateRst = '0;
		stateRst.main = RST_MAIN;
		for (int i = 0; i < RW_COUNT; i++) begin
			stateRst.rwRegs[i] = RW_RESET[i];
		end
		stateRst.ramp = RST_RAMP;
		stateRst.offDelay = RST_OFFDLY;
		stateRst.alertOe_n = 1'b1;
		stateRst.scanEnable = '1;
		stateRst.gainFactor = 4'h1;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		stateNext = stateReg;
		// Standby limits scanning; deep sleep stops it
		if (stateReg.main[DSLP_BIT]) begin
			sampled = '0;
		end else if (stateReg.main[STANDBY_ENABLE_BIT]) begin
			sampled = standbyChannels;
		end else begin
			sampled = '1;
		end
		// Inputs no longer sampled read as untouched
		touchSeen = touchRaw & sampled;
		intClear = wrEn && addr == ADDR_MAIN && !wrData[INT_BIT];
		enterSleep = wrEn && addr == ADDR_MAIN && wrData[DSLP_BIT] && !stateReg.main[DSLP_BIT];

		// Main control write
		if (wrEn && addr == ADDR_MAIN) begin
			stateNext.main[7:4] = wrData[7:4];
			stateNext.main[INT_BIT] = stateReg.main[INT_BIT] & wrData[INT_BIT];
		end
		// Touch flags: cleared on flag clear only when released
		if (intClear) begin
			stateNext.touched = stateReg.touched & touchSeen;
			stateNext.ledDone = '0;
		end
		// Set wins over a flag clear write, deep sleep entry clears all; touch and LED done flags hold until an interrupt flag clear write or deep sleep entry
		stateNext.touched = stateNext.touched | touchSeen;
		stateNext.ledDone = stateNext.ledDone | (ledDoneEvt & ~stateReg.ledLinkMask);
		stateNext.patternFlag = patternMatch;
		stateNext.multiFlag = multiTouchBlocking;
		// New touch on enabled input raises the flag; held touch does not
		if (|(touchSeen & ~stateReg.touched & intEnable)) begin
			stateNext.main[INT_BIT] = 1'b1;
		end
		if (patternMatch && !stateReg.patternFlag && patternAlertEnable) begin
			stateNext.main[INT_BIT] = 1'b1;
		end
		if (enterSleep) begin
			stateNext.touched = '0;
			stateNext.ledDone = '0;
			stateNext.patternFlag = 1'b0;
			stateNext.multiFlag = 1'b0;
			stateNext.main[INT_BIT] = 1'b0;
		end

		// Writable LED configuration registers
		for (int i = 0; i < RW_COUNT; i++) begin
			if (wrEn && addr == RW_ADDR[i]) begin
				stateNext.rwRegs[i] = wrData;
			end
		end
		if (wrEn && addr == ADDR_RAMP) begin
			stateNext.ramp = wrData;
		end
		if (wrEn && addr == ADDR_OFFDLY) begin
			stateNext.offDelay = wrData;
		end

		// Status and readback
		genStatus = '0;
		genStatus[GEN_LED] = |stateReg.ledDone;
		genStatus[GEN_MULTI_TOUCH_BLOCKING] = stateReg.multiFlag;
		genStatus[GEN_MTP] = stateReg.patternFlag;
		genStatus[GEN_TOUCH] = |stateReg.touched;
		rdMux = 8'h00;
		case (addr)
			ADDR_MAIN:    rdMux = {stateReg.main[7:4], 3'h0, stateReg.main[INT_BIT]};
			ADDR_GEN:     rdMux = genStatus;
			ADDR_INPUT:   rdMux = {5'h00, stateReg.touched};
			ADDR_LEDDONE: rdMux = {5'h00, stateReg.ledDone};
			ADDR_RAMP:    rdMux = stateReg.ramp;
			ADDR_OFFDLY:  rdMux = stateReg.offDelay;
			ADDR_CAL1:    rdMux = calUpper1;
			ADDR_CAL2:    rdMux = calUpper2;
			ADDR_CAL3:    rdMux = calUpper3;
			ADDR_CALLSB:  rdMux = calLowBits;
			ADDR_PID:     rdMux = ID_PART;
			ADDR_MID:     rdMux = ID_MAKER;
			ADDR_REV:     rdMux = ID_REV;
			default: begin
				for (int i = 0; i < RW_COUNT; i++) begin
					if (addr == RW_ADDR[i]) begin
						rdMux = stateReg.rwRegs[i];
					end
				end
			end
		endcase
		if (rdEn) begin
			stateNext.rdData = rdMux;
		end

		// Control outputs
		stateNext.gainCode = stateNext.main[7:GAIN_LSB];
		stateNext.gainFactor = 4'(4'h1 << stateNext.main[7:GAIN_LSB]);
		if (stateNext.main[DSLP_BIT]) begin
			stateNext.scanEnable = '0;
		end else if (stateNext.main[STANDBY_ENABLE_BIT]) begin
			stateNext.scanEnable = standbyChannels;
		end else begin
			stateNext.scanEnable = '1;
		end
		stateNext.ledsIdle = stateNext.main[DSLP_BIT];
		stateNext.pwmHalt = stateNext.main[DSLP_BIT];
		// Linking unchanged by standby; deep sleep releases all
		linkNext = stateNext.rwRegs[LINK_IDX][NCH-1:0];
		stateNext.ledLinkMask = stateNext.main[DSLP_BIT] ? '0 : linkNext;
		stateNext.alertOe_n = ~stateNext.main[INT_BIT];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			stateReg <= stateRst;
		end else begin
			stateReg <= stateNext;
		end
	end

	assign rdData      = stateReg.rdData;
	assign gainCode    = stateReg.gainCode;
	assign gainFactor  = stateReg.gainFactor;
	assign scanEnable  = stateReg.scanEnable;
	assign ledsIdle    = stateReg.ledsIdle;
	assign pwmHalt     = stateReg.pwmHalt;
	assign ledLinkMask = stateReg.ledLinkMask;
	assign alertOut    = 1'b0;
	assign alertOe_n   = stateReg.alertOe_n;

	// ****************************************
	// Assertions: reset and readback
	// ****************************************
	AST_RESET_DEFAULTS: assert property (@(posedge mclk) disable iff (rst)
		$past(rst)
		|-> stateReg.main == RST_MAIN && alertOe_n && rdData == 8'h00 && gainFactor == 4'h1)
		else $error("reset defaults wrong");
	AST_UNDEF_READ_ZERO: assert property (@(posedge mclk) disable iff (rst)
		rdEn && addr == 8'h01
		|=> rdData == 8'h00)
		else $error("undefined read not zero");
	AST_UNDEF_WRITE_IGNORED: assert property (@(posedge mclk) disable iff (rst)
		wrEn && addr == 8'h01
		|=> stateReg.rwRegs == $past(stateReg.rwRegs) && stateReg.ramp == $past(stateReg.ramp))
		else $error("undefined write changed state");
	AST_ID_FIXED: assert property (@(posedge mclk) disable iff (rst)
		rdEn && addr == ADDR_PID
		|=> rdData == ID_PART)
		else $error("identity changed");
	AST_ID_MAKER: assert property (@(posedge mclk) disable iff (rst)
		rdEn && addr == ADDR_MID
		|=> rdData == ID_MAKER)
		else $error("maker identity changed");
	AST_ID_REV: assert property (@(posedge mclk) disable iff (rst)
		rdEn && addr == ADDR_REV
		|=> rdData == ID_REV)
		else $error("revision identity changed");

	// ****************************************
	// Assertions: gain and power states
	// ****************************************
	AST_GAIN_DECODE: assert property (@(posedge mclk) disable iff (rst)
		1'b1
		|-> gainFactor == 4'(4'h1 << gainCode))
		else $error("gain decode wrong");
	AST_GAIN_FOLLOWS_MAIN: assert property (@(posedge mclk) disable iff (rst)
		1'b1
		|-> gainCode == stateReg.main[7:GAIN_LSB])
		else $error("gain not from main control");
	AST_STANDBY_SCAN: assert property (@(posedge mclk) disable iff (rst)
		stateReg.main[STANDBY_ENABLE_BIT] && !stateReg.main[DSLP_BIT]
		|-> scanEnable == $past(standbyChannels))
		else $error("standby scan set wrong");
	AST_ACTIVE_SCAN: assert property (@(posedge mclk) disable iff (rst)
		!stateReg.main[STANDBY_ENABLE_BIT] && !stateReg.main[DSLP_BIT]
		|-> scanEnable == '1)
		else $error("active scan set wrong");
	AST_LINK_KEPT: assert property (@(posedge mclk) disable iff (rst)
		!stateReg.main[DSLP_BIT]
		|-> ledLinkMask == stateReg.rwRegs[LINK_IDX][NCH-1:0])
		else $error("link mask lost");
	AST_DROPPED_INPUT_UNTOUCHED: assert property (@(posedge mclk) disable iff (rst)
		(stateReg.touched & ~sampled) == '0
		|=> (stateReg.touched & ~$past(sampled)) == '0)
		else $error("unsampled input touched");
	AST_SLEEP_NO_SCAN: assert property (@(posedge mclk) disable iff (rst)
		stateReg.main[DSLP_BIT]
		|-> scanEnable == '0 && pwmHalt && ledsIdle && ledLinkMask == '0)
		else $error("scan in sleep");
	AST_SLEEP_CLEARS: assert property (@(posedge mclk) disable iff (rst)
		enterSleep
		|=> !stateReg.main[INT_BIT] && stateReg.touched == '0 && stateReg.ledDone == '0)
		else $error("sleep did not clear");

	// ****************************************
	// Assertions: interrupt flag and alert
	// ****************************************
	AST_ALERT_FOLLOWS_INT: assert property (@(posedge mclk) disable iff (rst)
		1'b1
		|-> alertOe_n == !stateReg.main[INT_BIT])
		else $error("alert mismatch");
	AST_TOUCH_SETS_INT: assert property (@(posedge mclk) disable iff (rst)
		|(touchSeen & ~stateReg.touched & intEnable) && !enterSleep
		|=> stateReg.main[INT_BIT])
		else $error("touch did not raise interrupt");
	AST_DISABLED_NO_INT: assert property (@(posedge mclk) disable iff (rst)
		!stateReg.main[INT_BIT] && !wrEn && intEnable == '0 && !patternMatch
		|=> !stateReg.main[INT_BIT])
		else $error("interrupt from disabled input");
	AST_HELD_TOUCH_NO_REALERT: assert property (@(posedge mclk) disable iff (rst)
		!stateReg.main[INT_BIT] && (touchSeen & ~stateReg.touched) == '0 && !patternMatch
		|=> !stateReg.main[INT_BIT])
		else $error("held touch raised interrupt");
	AST_CLEAR_DROPS_ALERT: assert property (@(posedge mclk) disable iff (rst)
		intClear && !enterSleep && !(|(touchSeen & ~stateReg.touched & intEnable))
		&& !(patternMatch && !stateReg.patternFlag && patternAlertEnable) |=> alertOe_n)
		else $error("alert not released");
	AST_CLEAR_KEEPS_PRESENT: assert property (@(posedge mclk) disable iff (rst)
		intClear && !enterSleep
		|=> stateReg.touched == $past(touchSeen))
		else $error("touch flags wrong after clear");

	// ****************************************
	// Assertions: status registers
	// ****************************************
	AST_STATUS_HOLD: assert property (@(posedge mclk) disable iff (rst)
		!intClear && !enterSleep
		|=> (stateReg.touched & $past(stateReg.touched)) == $past(stateReg.touched))
		else $error("touch flag lost without clear");
	AST_TOUCH_SUMMARY: assert property (@(posedge mclk) disable iff (rst)
		rdEn && addr == ADDR_GEN
		|=> rdData[GEN_TOUCH] == ($past(stateReg.touched) != '0))
		else $error("touch summary wrong");
	AST_LED_SUMMARY: assert property (@(posedge mclk) disable iff (rst)
		rdEn && addr == ADDR_GEN
		|=> rdData[GEN_LED] == ($past(stateReg.ledDone) != '0))
		else $error("led summary wrong");
	AST_LED_CLEAR: assert property (@(posedge mclk) disable iff (rst)
		intClear && !enterSleep
		|=> stateReg.ledDone == $past(ledDoneEvt & ~stateReg.ledLinkMask))
		else $error("led done not cleared");
	AST_LINKED_DONE_IGNORED: assert property (@(posedge mclk) disable iff (rst)
		(ledDoneEvt & ~stateReg.ledLinkMask) == '0 && !intClear && !enterSleep
		|=> stateReg.ledDone == $past(stateReg.ledDone))
		else $error("linked led done recorded");
	AST_MULTI_TOUCH_BLOCKING_NO_INT: assert property (@(posedge mclk) disable iff (rst)
		multiTouchBlocking && !stateReg.main[INT_BIT] && (touchSeen & ~stateReg.touched) == '0 && !patternMatch
		|=> !stateReg.main[INT_BIT])
		else $error("blocking raised interrupt");
	AST_PATTERN_INT: assert property (@(posedge mclk) disable iff (rst)
		patternMatch && !stateReg.patternFlag && patternAlertEnable && !enterSleep
		|=> stateReg.main[INT_BIT])
		else $error("pattern did not raise interrupt");
	AST_PATTERN_FOLLOWS: assert property (@(posedge mclk) disable iff (rst)
		!enterSleep
		|=> stateReg.patternFlag == $past(patternMatch))
		else $error("pattern flag wrong");

	// ****************************************
	// Coverage
	// ****************************************
	COV_TOUCH_INT: cover property (@(posedge mclk) disable iff (rst)
		$rose(stateReg.main[INT_BIT]));
	COV_STANDBY: cover property (@(posedge mclk) disable iff (rst)
		$rose(stateReg.main[STANDBY_ENABLE_BIT]));
	COV_SLEEP: cover property (@(posedge mclk) disable iff (rst)
		enterSleep);
	COV_CLEAR: cover property (@(posedge mclk) disable iff (rst)
		intClear && stateReg.main[INT_BIT]);
	COV_PATTERN_INT: cover property (@(posedge mclk) disable iff (rst)
		patternMatch && !stateReg.patternFlag && patternAlertEnable);
endmodule
`default_nettype wire

/* File: inc/tsc_pkg.sv */
/*
 Package for the touch sensor control and status register bank: offsets, reset values, field positions.
 Assumes a serial front end that presents decoded byte reads and writes on the device clock.
*/
package tsc_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_MAIN    = 8'h00;
	localparam logic [7:0] ADDR_GEN     = 8'h02;
	localparam logic [7:0] ADDR_INPUT   = 8'h03;
	localparam logic [7:0] ADDR_LEDDONE = 8'h04;
	localparam logic [7:0] ADDR_PID     = 8'hFD;
	localparam logic [7:0] ADDR_MID     = 8'hFE;
	localparam logic [7:0] ADDR_REV     = 8'hFF;
	localparam int RW_COUNT = 14;
	localparam logic [7:0] RW_ADDR [RW_COUNT] = '{8'h72, 8'h73, 8'h74, 8'h77, 8'h79, 8'h81,
		8'h84, 8'h85, 8'h86, 8'h88, 8'h90, 8'h91, 8'h92, 8'h93};
	localparam logic [7:0] RW_RESET [RW_COUNT] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h20, 8'h14, 8'h5D, 8'h04, 8'hF0, 8'hF0, 8'hF0, 8'hF0};
	localparam logic [7:0] ADDR_RAMP    = 8'h94;
	localparam logic [7:0] ADDR_OFFDLY  = 8'h95;
	localparam logic [7:0] RST_RAMP     = 8'h00;
	localparam logic [7:0] RST_OFFDLY   = 8'h00;
	localparam int LINK_IDX = 0;
	localparam logic [7:0] ADDR_CAL1    = 8'hB1;
	localparam logic [7:0] ADDR_CAL2    = 8'hB2;
	localparam logic [7:0] ADDR_CAL3    = 8'hB3;
	localparam logic [7:0] ADDR_CALLSB  = 8'hB9;
	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam logic [7:0] RST_MAIN     = 8'h00;
	localparam int GAIN_LSB  = 6;
	localparam int STANDBY_ENABLE_BIT  = 5;
	localparam int DSLP_BIT  = 4;
	localparam int INT_BIT   = 0;
	localparam int GEN_LED   = 4;
	localparam int GEN_MULTI_TOUCH_BLOCKING  = 2;
	localparam int GEN_MTP   = 1;
	localparam int GEN_TOUCH = 0;
	localparam int NCH       = 3;
	// Identity values are arbitrary
	localparam logic [7:0] ID_PART  = 8'hA1;
	localparam logic [7:0] ID_MAKER = 8'hB2;
	localparam logic [7:0] ID_REV   = 8'h01;
endpackage

/* File: tb/testbench.sv */
/*
 Self-checking bench: register model, touch, status and power states.
 Assumes the host model drives the register port.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench import tsc_pkg::*;;
	logic mclk, rst, multi, patt, pattEn, ledsIdle, pwmHalt, alertOut, alertOe_n;
	logic wrEn, rdEn;
	logic [7:0] addr, wrData, rdData, c1, c2, c3, cl, v, r;
	logic [NCH-1:0] touch, intEn, sbCh, ledEvt, scanEnable, ledLinkMask;
	logic [1:0] gainCode;
	logic [3:0] gainFactor;
	logic [7:0] mdl [int];
	int mismatches;
	int checksDone;
	tsc_host host (.mclk(mclk), .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData), .rdData(rdData));
	tsc_regs dut (.mclk(mclk), .rst(rst), .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData),
		.rdData(rdData), .touchRaw(touch), .intEnable(intEn), .standbyChannels(sbCh),
		.ledDoneEvt(ledEvt), .multiTouchBlocking(multi), .patternMatch(patt),
		.patternAlertEnable(pattEn), .calUpper1(c1), .calUpper2(c2), .calUpper3(c3),
		.calLowBits(cl), .gainCode(gainCode), .gainFactor(gainFactor), .scanEnable(scanEnable),
		.ledsIdle(ledsIdle), .pwmHalt(pwmHalt), .ledLinkMask(ledLinkMask), .alertOut(alertOut),
		.alertOe_n(alertOe_n));
	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		checksDone++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rc(input int a);
		host.rd(a[7:0], v);
		check($sformatf("reg %h", a), v, mdl.exists(a) ? mdl[a] : 8'h00);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic waitAlert(input logic lvl);
		int k;
		k = 0;
		while (alertOe_n !== lvl && k < 8) begin
			tick(1);
			k++;
		end
		check("alertOe_n", {7'h00, alertOe_n}, {7'h00, lvl});
		if (alertOe_n !== lvl)
			end_of_test();
	endtask
	function automatic bit rw(input int a);
		rw = (a == ADDR_RAMP || a == ADDR_OFFDLY);
		foreach (RW_ADDR[i])
			if (RW_ADDR[i] == a)
				rw = 1'b1;
	endfunction
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		void'($urandom(87));
		{c1, c2, c3, cl} = $urandom;
		{touch, intEn, ledEvt, multi, patt, pattEn} = '0;
		sbCh = 3'b010;
		rst = 1'b1;
		foreach (RW_ADDR[i])
			mdl[RW_ADDR[i]] = RW_RESET[i];
		mdl[ADDR_RAMP] = RST_RAMP;
		mdl[ADDR_OFFDLY] = RST_OFFDLY;
		mdl[ADDR_MAIN] = RST_MAIN;
		mdl[ADDR_PID] = ID_PART;
		mdl[ADDR_MID] = ID_MAKER;
		mdl[ADDR_REV] = ID_REV;
		mdl[ADDR_CAL1] = c1;
		mdl[ADDR_CAL2] = c2;
		mdl[ADDR_CAL3] = c3;
		mdl[ADDR_CALLSB] = cl;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		tick(1);
		check("alertOe_n", {7'h00, alertOe_n}, 8'h01);
		check("gainFactor", {4'h0, gainFactor}, 8'h01);
		for (int a = 0; a < 256; a++)
			rc(a);
		$display("reset map done");
		for (int a = 1; a < 256; a++) begin
			r = 8'($urandom);
			host.wr(a[7:0], r);
			if (rw(a))
				mdl[a] = r;
		end
		check("ledLinkMask", {5'h00, ledLinkMask}, {5'h00, mdl[8'h72][2:0]});
		for (int a = 0; a < 256; a++)
			rc(a);
		$display("write map done");
		for (int g = 0; g < 8; g++) begin
			host.wr(ADDR_MAIN, {g[1:0], g[2], 5'h00});
			check("gainFactor", {4'h0, gainFactor}, 8'(1 << g[1:0]));
			check("scanEnable", {5'h00, scanEnable}, g[2] ? {5'h00, sbCh} : 8'h07);
		end
		host.wr(ADDR_MAIN, 8'h00);
		$display("gain and standby done");
		intEn <= 3'b001;
		touch <= 3'b010;
		tick(4);
		check("alertOe_n", {7'h00, alertOe_n}, 8'h01);
		mdl[3] = 8'h02;
		mdl[2] = 8'h01;
		rc(ADDR_MAIN);
		rc(ADDR_INPUT);
		touch <= 3'b011;
		waitAlert(1'b0);
		mdl[3] = 8'h03;
		mdl[0] = 8'h01;
		rc(ADDR_INPUT);
		rc(ADDR_GEN);
		rc(ADDR_MAIN);
		touch <= 3'b001;
		host.clearInt(8'h00);
		mdl[3] = 8'h01;
		mdl[0] = 8'h00;
		waitAlert(1'b1);
		rc(ADDR_INPUT);
		tick(6);
		check("alertOe_n", {7'h00, alertOe_n}, 8'h01);
		touch <= 3'b000;
		host.clearInt(8'h00);
		mdl[3] = 8'h00;
		mdl[2] = 8'h00;
		rc(ADDR_GEN);
		$display("touch done");
		host.wr(8'h72, 8'h00);
		mdl[8'h72] = 8'h00;
		@(posedge mclk);
		ledEvt <= 3'b100;
		@(posedge mclk);
		ledEvt <= 3'b000;
		tick(2);
		mdl[4] = 8'h04;
		mdl[2] = 8'h10;
		rc(ADDR_LEDDONE);
		rc(ADDR_GEN);
		host.clearInt(8'h00);
		mdl[4] = 8'h00;
		mdl[2] = 8'h00;
		rc(ADDR_LEDDONE);
		rc(ADDR_GEN);
		$display("led done");
		multi <= 1'b1;
		patt <= 1'b1;
		tick(4);
		check("alertOe_n", {7'h00, alertOe_n}, 8'h01);
		mdl[2] = 8'h06;
		rc(ADDR_GEN);
		patt <= 1'b0;
		tick(2);
		mdl[2] = 8'h04;
		rc(ADDR_GEN);
		pattEn <= 1'b1;
		patt <= 1'b1;
		waitAlert(1'b0);
		host.clearInt(8'h00);
		mdl[2] = 8'h06;
		rc(ADDR_GEN);
		{multi, patt} <= 2'b00;
		host.clearInt(8'h00);
		mdl[2] = 8'h00;
		rc(ADDR_GEN);
		$display("pattern done");
		touch <= 3'b001;
		waitAlert(1'b0);
		host.wr(ADDR_MAIN, 8'h10);
		mdl[0] = 8'h10;
		mdl[3] = 8'h00;
		waitAlert(1'b1);
		rc(ADDR_MAIN);
		rc(ADDR_INPUT);
		check("sleep", {5'h00, ledsIdle, pwmHalt, ledLinkMask == 3'b000}, 8'h07);
		check("scanEnable", {5'h00, scanEnable}, 8'h00);
		$display("deep sleep done");
		end_of_test();
	end
endmodule
`default_nettype wire

/* File: tb/tsc_host.sv */
/*
 Host model: byte writes and reads to the register bank.
 Assumes one mclk domain and rdData one cycle after the read strobe.
*/
`timescale 1ns/1ns
`default_nettype none
module tsc_host
	import tsc_pkg::*;
(
	input  wire logic       mclk,
	output logic            wrEn,
	output logic            rdEn,
	output logic [7:0]      addr,
	output logic [7:0]      wrData,
	input  wire logic [7:0] rdData
);
	// ****************************************
	// Bus cycles
	// ****************************************
	initial begin
		wrEn = 1'b0;
		rdEn = 1'b0;
		addr = 8'h00;
		wrData = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge mclk);
		wrEn <= 1'b0;
		wrData <= ~d;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge mclk);
		rdEn <= 1'b0;
		#1;
		d = rdData;
	endtask
	// Interrupt clear writes keep to the other main bits
	task automatic clearInt(input logic [7:0] keep);
		wr(ADDR_MAIN, keep & 8'hFE);
	endtask
endmodule
`default_nettype wire
